// ==== core/drive_input_mode_selector.sv ====
// Operation
// - code 26 in a slot selects gain set
// - selector off primary gains, on alternate gains
// - unassigned selector means primary gains
// - taper between gain sets over programmed ms
// - gain switching only in vector control methods
// - raise input ramps speed up, else holds
// - lower input ramps speed down, else holds
// - clear input erases stored adjusted speed
// - adjust only with source 01 multistep or 02
// - no adjust with analog reference or jog
// - ramp rate from active profile set
// - storage 00 reverts to base after power return
// - storage 01 restores stored value after power
// - override input takes keypad setpoint and run
// - override change while running stops output
// - code 43 on selects P-only compensation in vector control methods
// - unassigned compensation input means PI always
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module drive_input_mode_selector #(
	parameter int unsigned MS_CYCLES = mode_sel_pkg::MS_TICK_CYCLES,
	parameter int unsigned FREQ_W    = 16
) (
	// Clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rst_b_in,
	// APB slave
	input  wire logic                         psel_in,
	input  wire logic                         penable_in,
	input  wire logic                         pwrite_in,
	input  wire logic [7:0]                   paddr_in,
	input  wire logic [31:0]                  pwdata_in,
	output var  logic                         pready_out,
	output var  logic [31:0]                  prdata_out,
	output var  logic                         pslverr_out,
	// Input terminal pins and power return pin
	input  wire logic [mode_sel_pkg::SLOTS-1:0] terminal_in,
	input  wire logic                         power_return_in,
	// Run and setpoint sources, same clock
	input  wire logic                         keypad_run_in,
	input  wire logic                         config_run_in,
	input  wire logic [FREQ_W-1:0]            keypad_setpoint_in,
	input  wire logic                         multistep_active_in,
	input  wire logic                         analog_ref_in,
	input  wire logic                         jog_active_in,
	// Drive outputs
	output var  mode_sel_pkg::gain_set_t      gains_out,
	output var  logic                         p_only_mode_out,
	output var  logic [FREQ_W-1:0]            setpoint_out,
	output var  logic                         run_out
);
	localparam int unsigned SLOT_AW = $clog2(mode_sel_pkg::SLOTS);
	localparam int unsigned MS_W    = $clog2(MS_CYCLES + 1);
	localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);
	localparam logic [7:0] FN_CODES [mode_sel_pkg::FN_COUNT] = '{
		mode_sel_pkg::FN_GAIN_SEL, mode_sel_pkg::FN_RAISE, mode_sel_pkg::FN_LOWER,
		mode_sel_pkg::FN_ADJ_CLEAR, mode_sel_pkg::FN_OVERRIDE, mode_sel_pkg::FN_COMP_MODE,
		mode_sel_pkg::FN_SET2, mode_sel_pkg::FN_THIRD_PROFILE_SELECT};
	localparam int unsigned F_GAIN = 0;
	localparam int unsigned F_UP   = 1;
	localparam int unsigned F_DN   = 2;
	localparam int unsigned F_CLR  = 3;
	localparam int unsigned F_OVR  = 4;
	localparam int unsigned F_PPI  = 5;
	localparam int unsigned F_SET2 = 6;
	localparam int unsigned F_THIRD_PROFILE_SELECT = 7;

	typedef enum logic [1:0] {RUN_IDLE, RUN_ACTIVE, RUN_BLOCKED} run_state_t;

	function automatic logic [15:0] taper_step(input logic [15:0] cur, input logic [15:0] tgt,
			input logic [13:0] rem);
		logic signed [17:0] diff;
		logic signed [17:0] step;
		diff = $signed({2'b00, tgt}) - $signed({2'b00, cur});
		step = diff / $signed({4'b0000, rem});
		taper_step = 16'(cur + step[15:0]);
	endfunction : taper_step

	function automatic logic fn_on(input logic [mode_sel_pkg::SLOTS-1:0] mask,
			input logic [mode_sel_pkg::SLOTS-1:0] pins);
		fn_on = |(mask & pins);
	endfunction : fn_on

	// Configuration registers
	logic [7:0]          ctrl_method_q;
	logic [7:0]          freq_src_q;
	logic [7:0]          run_src_q;
	logic [7:0]          storage_q;
	mode_sel_pkg::gain_set_t primary_q;
	mode_sel_pkg::gain_set_t alt_q;
	logic [13:0]         taper_time_q;
	logic [FREQ_W-1:0]   base_freq_q;
	logic [15:0]         accel_q [3];
	logic [15:0]         decel_q [3];

	logic [mode_sel_pkg::SLOTS-1:0] term_s;
	logic                power_s;
	logic                power_prev_q;
	logic [mode_sel_pkg::SLOTS-1:0] fn_mask_q [mode_sel_pkg::FN_COUNT];

	// APB decode
	logic                access;
	logic                commit_wr;
	logic                slot_addr;
	logic                slot_wait_q;
	logic                mapped;
	logic [SLOT_AW-1:0]  slot_idx;
	logic [SLOT_AW-1:0]  scan_q;
	logic [SLOT_AW-1:0]  scan_prev_q;
	logic                scan_valid_q;
	logic [SLOT_AW-1:0]  mem_raddr;
	logic [7:0]          mem_rdata;
	mode_sel_pkg::status_t status;
	logic [FREQ_W-1:0]   stored_q;

	assign access    = psel_in & penable_in;
	assign commit_wr = access & pready_out & pwrite_in;
	assign slot_addr = (paddr_in >= mode_sel_pkg::OFF_SLOT_BASE) && (paddr_in <= mode_sel_pkg::OFF_SLOT_LAST)
		&& (paddr_in[1:0] == 2'b00);
	assign slot_idx  = paddr_in[SLOT_AW+1:2];
	assign mem_raddr = (psel_in & slot_addr & ~pwrite_in) ? slot_idx : scan_q;

	always_comb begin
		case (paddr_in)
			mode_sel_pkg::OFF_CONFIG, mode_sel_pkg::OFF_PRIM_PI, mode_sel_pkg::OFF_P_ONLY,
			mode_sel_pkg::OFF_ALT_PI, mode_sel_pkg::OFF_TAPER, mode_sel_pkg::OFF_BASE_FREQ,
			mode_sel_pkg::OFF_RAMP_SET1, mode_sel_pkg::OFF_RAMP_SET2, mode_sel_pkg::OFF_RAMP_THIRD_PROFILE_SELECT,
			mode_sel_pkg::OFF_SETPOINT, mode_sel_pkg::OFF_STATUS, mode_sel_pkg::OFF_STORED: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = slot_addr;
			end
		endcase
	end

	pin_sync #(.WIDTH(mode_sel_pkg::SLOTS + 1)) u_pin_sync (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.async_in ({power_return_in, terminal_in}),
		.sync_out ({power_s, term_s})
	);

	slot_table_mem #(.DEPTH(mode_sel_pkg::SLOTS), .WIDTH(8)) u_slot_table (
		.clk_in      (clk_in),
		.rst_b_in    (rst_b_in),
		.wr_en_in    (commit_wr & slot_addr),
		.wr_addr_in  (slot_idx),
		.wr_data_in  (pwdata_in[7:0]),
		.rd_addr_in  (mem_raddr),
		.rd_data_out (mem_rdata)
	);

	// Slot table read waits one extra cycle for the memory's registered output
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			slot_wait_q <= 1'b0;
		end else begin
			slot_wait_q <= access & ~pready_out & slot_addr & ~pwrite_in & ~slot_wait_q;
			pready_out  <= access & ~pready_out & (~(slot_addr & ~pwrite_in) | slot_wait_q);
			pslverr_out <= access & ~pready_out & ~mapped;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (access & ~pready_out & (~pwrite_in | ~mapped)) begin
			case (paddr_in)
				mode_sel_pkg::OFF_CONFIG:    prdata_out <= {storage_q, run_src_q, freq_src_q, ctrl_method_q};
				mode_sel_pkg::OFF_PRIM_PI:   prdata_out <= {primary_q.pi_integral, primary_q.pi_prop};
				mode_sel_pkg::OFF_P_ONLY:    prdata_out <= {alt_q.p_only, primary_q.p_only};
				mode_sel_pkg::OFF_ALT_PI:    prdata_out <= {alt_q.pi_integral, alt_q.pi_prop};
				mode_sel_pkg::OFF_TAPER:     prdata_out <= {18'h0_0000, taper_time_q};
				mode_sel_pkg::OFF_BASE_FREQ: prdata_out <= 32'(base_freq_q);
				mode_sel_pkg::OFF_RAMP_SET1: prdata_out <= {decel_q[0], accel_q[0]};
				mode_sel_pkg::OFF_RAMP_SET2: prdata_out <= {decel_q[1], accel_q[1]};
				mode_sel_pkg::OFF_RAMP_THIRD_PROFILE_SELECT: prdata_out <= {decel_q[2], accel_q[2]};
				mode_sel_pkg::OFF_SETPOINT:  prdata_out <= 32'(setpoint_out);
				mode_sel_pkg::OFF_STATUS:    prdata_out <= 32'(status);
				mode_sel_pkg::OFF_STORED:    prdata_out <= 32'(stored_q);
				default:                     prdata_out <= slot_wait_q ? 32'(mem_rdata) : 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_method_q <= 8'h00;
			freq_src_q    <= 8'h00;
			run_src_q     <= 8'h00;
			storage_q     <= mode_sel_pkg::STORE_OFF;
			primary_q     <= '{mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::P_GAIN_RESET};
			alt_q         <= '{mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::P_GAIN_RESET};
			taper_time_q  <= mode_sel_pkg::TAPER_RESET;
			base_freq_q   <= '0;
			for (int i = 0; i < 3; i++) begin
				accel_q[i] <= mode_sel_pkg::RAMP_RESET;
				decel_q[i] <= mode_sel_pkg::RAMP_RESET;
			end
		end else if (commit_wr) begin
			case (paddr_in)
				mode_sel_pkg::OFF_CONFIG: begin
					{storage_q, run_src_q, freq_src_q, ctrl_method_q} <= pwdata_in;
				end
				mode_sel_pkg::OFF_PRIM_PI:   {primary_q.pi_integral, primary_q.pi_prop} <= pwdata_in;
				mode_sel_pkg::OFF_P_ONLY:    {alt_q.p_only, primary_q.p_only} <= pwdata_in;
				mode_sel_pkg::OFF_ALT_PI:    {alt_q.pi_integral, alt_q.pi_prop} <= pwdata_in;
				mode_sel_pkg::OFF_TAPER:     taper_time_q <= pwdata_in[13:0];
				mode_sel_pkg::OFF_BASE_FREQ: base_freq_q <= pwdata_in[FREQ_W-1:0];
				mode_sel_pkg::OFF_RAMP_SET1: {decel_q[0], accel_q[0]} <= pwdata_in;
				mode_sel_pkg::OFF_RAMP_SET2: {decel_q[1], accel_q[1]} <= pwdata_in;
				mode_sel_pkg::OFF_RAMP_THIRD_PROFILE_SELECT: {decel_q[2], accel_q[2]} <= pwdata_in;
				default: begin
				end
			endcase
		end
	end

	// Slot scanner rebuilds each function's terminal mask; pauses while the bus owns the read port
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scan_q       <= '0;
			scan_prev_q  <= '0;
			scan_valid_q <= 1'b0;
			for (int f = 0; f < mode_sel_pkg::FN_COUNT; f++) begin
				fn_mask_q[f] <= '0;
			end
		end else begin
			scan_valid_q <= (mem_raddr == scan_q);
			scan_prev_q  <= scan_q;
			if (mem_raddr == scan_q) begin
				scan_q <= SLOT_AW'(scan_q + 1'b1);
			end
			if (scan_valid_q) begin
				for (int f = 0; f < mode_sel_pkg::FN_COUNT; f++) begin
					fn_mask_q[f][scan_prev_q] <= (mem_rdata == FN_CODES[f]);
				end
			end
		end
	end

	// Mode decode
	logic vector_mode;
	logic sel_alt;
	logic raise_on;
	logic lower_on;
	logic override_on;
	logic adjust_en;
	logic [1:0] profile;
	assign vector_mode = (ctrl_method_q == mode_sel_pkg::CM_SLV) || (ctrl_method_q == mode_sel_pkg::CM_ZERO_SLV)
		|| (ctrl_method_q == mode_sel_pkg::CM_SENSOR_VEC);
	// An empty mask reads as off, so an unassigned selector keeps the primary set
	assign sel_alt     = vector_mode & fn_on(fn_mask_q[F_GAIN], term_s);
	assign raise_on    = fn_on(fn_mask_q[F_UP], term_s);
	assign lower_on    = fn_on(fn_mask_q[F_DN], term_s);
	assign override_on = fn_on(fn_mask_q[F_OVR], term_s);
	assign adjust_en   = ((freq_src_q == mode_sel_pkg::FSRC_KEYPAD)
		|| ((freq_src_q == mode_sel_pkg::FSRC_TERMINAL) & multistep_active_in))
		& ~analog_ref_in & ~jog_active_in;
	assign profile     = fn_on(fn_mask_q[F_THIRD_PROFILE_SELECT], term_s) ? 2'd2
		: (fn_on(fn_mask_q[F_SET2], term_s) ? 2'd1 : 2'd0);

	// Millisecond tick for the gain taper
	logic [MS_W-1:0] ms_cnt_q;
	logic            ms_tick;
	assign ms_tick = (ms_cnt_q == MS_LAST);
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : MS_W'(ms_cnt_q + 1'b1);
		end
	end

	// Gain taper: each tick closes 1/remaining of the gap, so the last tick lands exactly
	mode_sel_pkg::gain_set_t target;
	mode_sel_pkg::gain_set_t target_q;
	logic [13:0]             taper_rem_q;
	assign target = sel_alt ? alt_q : primary_q;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gains_out   <= '{mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::P_GAIN_RESET};
			target_q    <= '{mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::PI_GAIN_RESET, mode_sel_pkg::P_GAIN_RESET};
			taper_rem_q <= '0;
		end else begin
			target_q <= target;
			if (target != target_q) begin
				taper_rem_q <= taper_time_q;
				if (taper_time_q == '0) begin
					gains_out <= target;
				end
			end else if ((taper_rem_q != '0) & ms_tick) begin
				gains_out.pi_prop     <= taper_step(gains_out.pi_prop, target.pi_prop, taper_rem_q);
				gains_out.pi_integral <= taper_step(gains_out.pi_integral, target.pi_integral, taper_rem_q);
				gains_out.p_only      <= taper_step(gains_out.p_only, target.p_only, taper_rem_q);
				taper_rem_q           <= 14'(taper_rem_q - 1'b1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p_only_mode_out <= 1'b0;
		end else begin
			p_only_mode_out <= vector_mode & fn_on(fn_mask_q[F_PPI], term_s);
		end
	end

	// Raise/lower ramp and stored value
	logic [FREQ_W-1:0] adj_q;
	logic              stored_valid_q;
	logic [15:0]       ramp_cnt_q;
	logic [15:0]       ramp_period;
	logic              ramping;
	logic              power_return;
	assign ramping      = adjust_en & (raise_on ^ lower_on);
	assign ramp_period  = raise_on ? accel_q[profile] : decel_q[profile];
	assign power_return = power_s & ~power_prev_q;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			power_prev_q <= 1'b0;
			ramp_cnt_q   <= '0;
			adj_q        <= '0;
		end else begin
			power_prev_q <= power_s;
			ramp_cnt_q   <= (ramping & (ramp_cnt_q < ramp_period)) ? 16'(ramp_cnt_q + 1'b1) : '0;
			if (power_return) begin
				adj_q <= ((storage_q == mode_sel_pkg::STORE_ON) & stored_valid_q) ? stored_q
					: base_freq_q;
			end else if (fn_on(fn_mask_q[F_CLR], term_s) | (commit_wr & (paddr_in == mode_sel_pkg::OFF_BASE_FREQ))) begin
				adj_q <= commit_wr ? pwdata_in[FREQ_W-1:0] : base_freq_q;
			end else if (ramping & (ramp_cnt_q >= ramp_period)) begin
				if (raise_on & (adj_q != '1)) begin
					adj_q <= FREQ_W'(adj_q + 1'b1);
				end else if (lower_on & (adj_q != '0)) begin
					adj_q <= FREQ_W'(adj_q - 1'b1);
				end
			end
		end
	end

	// Stored copy survives power return; only reset and the clear input drop it
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stored_q       <= '0;
			stored_valid_q <= 1'b0;
		end else if (fn_on(fn_mask_q[F_CLR], term_s)) begin
			stored_q       <= '0;
			stored_valid_q <= 1'b0;
		end else if ((storage_q == mode_sel_pkg::STORE_ON) & ~power_return & (adj_q != base_freq_q)) begin
			stored_q       <= adj_q;
			stored_valid_q <= 1'b1;
		end
	end

	// Run command path with override stop
	run_state_t run_state_q;
	logic       override_q;
	logic       run_src;
	assign run_src = override_on ? keypad_run_in : config_run_in;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_state_q <= RUN_IDLE;
			override_q  <= 1'b0;
		end else begin
			override_q <= override_on;
			case (run_state_q)
				RUN_IDLE: begin
					if (run_src) begin
						run_state_q <= RUN_ACTIVE;
					end
				end
				RUN_ACTIVE: begin
					if (override_on != override_q) begin
						run_state_q <= RUN_BLOCKED;
					end else if (!run_src) begin
						run_state_q <= RUN_IDLE;
					end
				end
				RUN_BLOCKED: begin
					if (!keypad_run_in & !config_run_in) begin
						run_state_q <= RUN_IDLE;
					end
				end
				default: begin
					run_state_q <= RUN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_out      <= 1'b0;
			setpoint_out <= '0;
		end else begin
			run_out      <= (run_state_q == RUN_ACTIVE) & (override_on == override_q) & run_src;
			setpoint_out <= override_on ? keypad_setpoint_in : (adjust_en ? adj_q : base_freq_q);
		end
	end

	assign status = '{tapering: (taper_rem_q != '0), stored_valid: stored_valid_q, adjust_active: ramping,
		run_blocked: (run_state_q == RUN_BLOCKED), panel_override: override_on, p_only_mode: p_only_mode_out,
		alt_gains: sel_alt, run: run_out};
endmodule : drive_input_mode_selector
`default_nettype wire

// ==== core/mode_sel_pkg.sv ====
package mode_sel_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG     = 8'h00;
	localparam logic [7:0] OFF_PRIM_PI    = 8'h04;
	localparam logic [7:0] OFF_P_ONLY     = 8'h08;
	localparam logic [7:0] OFF_ALT_PI     = 8'h0c;
	localparam logic [7:0] OFF_TAPER      = 8'h10;
	localparam logic [7:0] OFF_BASE_FREQ  = 8'h14;
	localparam logic [7:0] OFF_RAMP_SET1  = 8'h18;
	localparam logic [7:0] OFF_RAMP_SET2  = 8'h1c;
	localparam logic [7:0] OFF_RAMP_THIRD_PROFILE_SELECT  = 8'h20;
	localparam logic [7:0] OFF_SETPOINT   = 8'h28;
	localparam logic [7:0] OFF_STATUS     = 8'h2c;
	localparam logic [7:0] OFF_STORED     = 8'h30;
	localparam logic [7:0] OFF_SLOT_BASE  = 8'h40;
	localparam logic [7:0] OFF_SLOT_LAST  = 8'h5c;

	// Input slot function codes
	localparam logic [7:0] FN_SET2        = 8'h08;
	localparam logic [7:0] FN_THIRD_PROFILE_SELECT        = 8'h11;
	localparam logic [7:0] FN_GAIN_SEL    = 8'h1a;
	localparam logic [7:0] FN_RAISE       = 8'h1b;
	localparam logic [7:0] FN_LOWER       = 8'h1c;
	localparam logic [7:0] FN_ADJ_CLEAR   = 8'h1d;
	localparam logic [7:0] FN_OVERRIDE    = 8'h1f;
	localparam logic [7:0] FN_COMP_MODE   = 8'h2b;

	// Setting codes
	localparam logic [7:0] CM_SLV         = 8'h03;
	localparam logic [7:0] CM_ZERO_SLV    = 8'h04;
	localparam logic [7:0] CM_SENSOR_VEC  = 8'h05;
	localparam logic [7:0] FSRC_TERMINAL  = 8'h01;
	localparam logic [7:0] FSRC_KEYPAD    = 8'h02;
	localparam logic [7:0] STORE_OFF      = 8'h00;
	localparam logic [7:0] STORE_ON       = 8'h01;

	// Reset values
	localparam logic [15:0] PI_GAIN_RESET = 16'h03e8;
	localparam logic [15:0] P_GAIN_RESET  = 16'h0064;
	localparam logic [13:0] TAPER_RESET   = 14'h0064;
	localparam logic [15:0] RAMP_RESET    = 16'h0100;

	// Taper time base: one millisecond of the 250 MHz clock
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned TAPER_UNIT_US  = 1000;
	localparam int unsigned MS_TICK_CYCLES = TAPER_UNIT_US * CLK_MHZ;

	localparam int unsigned SLOTS          = 8;
	localparam int unsigned FN_COUNT       = 8;

	typedef struct packed {
		logic [15:0] pi_prop;
		logic [15:0] pi_integral;
		logic [15:0] p_only;
	} gain_set_t;

	typedef struct packed {
		logic        tapering;
		logic        stored_valid;
		logic        adjust_active;
		logic        run_blocked;
		logic        panel_override;
		logic        p_only_mode;
		logic        alt_gains;
		logic        run;
	} status_t;

endpackage : mode_sel_pkg

// ==== core/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ==== core/slot_table_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module slot_table_mem #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_b_in,
	// Write port
	input  wire logic                     wr_en_in,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
	input  wire logic [WIDTH-1:0]         wr_data_in,
	// Read port, data one cycle after address
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
	output var  logic [WIDTH-1:0]         rd_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= mem_q[rd_addr_in];
		end
	end
endmodule : slot_table_mem
`default_nettype wire

// ==== verification/mode_sel_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module mode_sel_assertions (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// Bus and run
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        pready_out,
	input  wire logic [31:0] prdata_out,
	input  wire logic        pslverr_out,
	input  wire logic        keypad_run_in,
	input  wire logic        config_run_in,
	input  wire logic        run_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	ready_in_access_a: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("pready outside an access");
	ready_one_cycle_a: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	err_zero_data_a: assert property (pslverr_out |-> prdata_out == 32'h0)
		else $error("error read data not zero");
	mapped_answer_a: assert property ($rose(penable_in) && psel_in && paddr_in <= 8'h14
		|-> ##1 (pready_out && !pslverr_out)) else $error("mapped access answer wrong");
	unmapped_err_a: assert property ($rose(penable_in) && psel_in && paddr_in > 8'h5c
		|-> ##[1:2] (pready_out && pslverr_out)) else $error("unmapped access not refused");
	run_source_a: assert property (run_out |-> $past(keypad_run_in || config_run_in))
		else $error("run without a source");
	run_release_a: assert property (!keypad_run_in && !config_run_in |=> !run_out)
		else $error("run stays after sources drop");
endmodule : mode_sel_assertions
bind drive_input_mode_selector mode_sel_assertions chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
	.prdata_out(prdata_out), .pslverr_out(pslverr_out), .keypad_run_in(keypad_run_in),
	.config_run_in(config_run_in), .run_out(run_out));
`default_nettype wire

// ==== verification/terminal_contacts.sv ====
`timescale 1ns/10ps
`default_nettype none
module terminal_contacts (
	// Clock
	input  wire logic       clk_in,
	// Commands from the bench
	input  wire logic [7:0] close_in,
	input  wire logic       run_in,
	// Contact levels
	output var  logic [7:0] terminal_out = 8'h00,
	output var  logic       run_out = 1'b0
);
	// Contacts change only at clock edges, so the design never sees a half-cycle glitch
	always @(posedge clk_in) begin
		terminal_out <= close_in;
		run_out <= run_in;
	end
endmodule : terminal_contacts
`default_nettype wire

// ==== verification/drive_input_mode_selector_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module drive_input_mode_selector_tb;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pwr = 1'b0, analog = 1'b0;
	logic [7:0] paddr = 8'h00, close = 8'h00, term;
	logic [31:0] pwdata = 32'h0, prdata;
	logic krun = 1'b0, crun_cmd = 1'b0, crun, p_only, run, ms = 1'b0, jog = 1'b0;
	logic [15:0] ksp = 16'h0abc, sp, s1, s2;
	mode_sel_pkg::gain_set_t gains;
	int n_mismatch = 0, checks_done = 0;
	localparam logic [47:0] PRIM = 48'h03e8_03e8_0064, ALT = 48'h0300_0200_0050;
	always #2 clk_in = ~clk_in;
	terminal_contacts ext (.clk_in(clk_in), .close_in(close), .run_in(crun_cmd), .terminal_out(term), .run_out(crun));
	drive_input_mode_selector #(.MS_CYCLES(10), .FREQ_W(16)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .terminal_in(term),
		.power_return_in(pwr), .keypad_run_in(krun), .config_run_in(crun), .keypad_setpoint_in(ksp),
		.multistep_active_in(ms), .analog_ref_in(analog), .jog_active_in(jog), .gains_out(gains),
		.p_only_mode_out(p_only), .setpoint_out(sp), .run_out(run));
	task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
		@(posedge clk_in);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		q = {pslverr, prdata};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [32:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	task automatic push(input logic [7:0] m, input int c, output logic [15:0] s);
		close <= m;
		cyc(c);
		close <= 8'h00;
		cyc(8);
		s = sp;
	endtask : push
	task automatic t_reset;
		logic [32:0] q;
		chk("reset gains", PRIM, gains);
		chk("reset comp", 0, p_only);
		apb(1'b0, mode_sel_pkg::OFF_TAPER, 0, q);
		chk("taper reset", 48'd100, q);
		apb(1'b0, 8'hfc, 0, q);
		chk("unmapped", 48'h1_0000_0000, q);
	endtask : t_reset
	task automatic t_gain;
		logic [7:0] m[3] = '{8'h03, 8'h04, 8'h05};
		wr(mode_sel_pkg::OFF_ALT_PI, 32'h0200_0300);
		wr(mode_sel_pkg::OFF_P_ONLY, 32'h0050_0064);
		wr(mode_sel_pkg::OFF_TAPER, 32'h2);
		wr(mode_sel_pkg::OFF_SLOT_BASE, mode_sel_pkg::FN_GAIN_SEL);
		close <= 8'h01;
		foreach (m[i]) begin
			wr(mode_sel_pkg::OFF_CONFIG, 32'h0200);
			cyc(40);
			chk("gains other method", PRIM, gains);
			wr(mode_sel_pkg::OFF_CONFIG, {24'h2, m[i]});
			cyc(2);
			chk("taper midway", 1, gains !== ALT);
			cyc(40);
			chk("alt gains", ALT, gains);
		end
		close <= 8'h00;
		cyc(40);
		chk("primary gains", PRIM, gains);
	endtask : t_gain
	task automatic t_comp;
		wr(mode_sel_pkg::OFF_SLOT_BASE + 8'h04, mode_sel_pkg::FN_COMP_MODE);
		close <= 8'h02;
		cyc(12);
		chk("p only on", 1, p_only);
		close <= 8'h00;
		cyc(10);
		chk("p only off", 0, p_only);
	endtask : t_comp
	task automatic t_ramp;
		wr(mode_sel_pkg::OFF_RAMP_SET2, 32'h00ff_00ff);
		wr(mode_sel_pkg::OFF_SLOT_BASE + 8'h18, mode_sel_pkg::FN_SET2);
		wr(mode_sel_pkg::OFF_RAMP_SET1, 32'h0004_0004);
		wr(mode_sel_pkg::OFF_BASE_FREQ, 32'h0100);
		for (int i = 2; i < 5; i++)
			wr(mode_sel_pkg::OFF_SLOT_BASE + 8'(4 * i), 32'(mode_sel_pkg::FN_RAISE + 8'(i - 2)));
		push(8'h04, 50, s1);
		chk("raise", 1, s1 > 16'h0100);
		push(8'h0c, 30, s2);
		chk("raise and lower", s1, s2);
		push(8'h08, 25, s2);
		chk("lower", 1, s2 < s1);
		push(8'h44, 30, s1);
		chk("slow profile", s2, s1);
		analog <= 1'b1;
		push(8'h04, 30, s1);
		chk("analog base", 16'h0100, s1);
		{analog, jog} <= 2'b01;
		push(8'h04, 30, s1);
		chk("jog base", 16'h0100, s1);
		jog <= 1'b0;
		cyc(2);
		chk("analog no adjust", s2, sp);
		wr(mode_sel_pkg::OFF_CONFIG, 32'h0105);
		push(8'h04, 30, s1);
		chk("terminal no multistep", 16'h0100, sp);
		ms <= 1'b1;
		push(8'h04, 30, s1);
		chk("terminal multistep", 1, s1 > s2);
		ms <= 1'b0;
		wr(mode_sel_pkg::OFF_CONFIG, 32'h0100_0205);
		push(8'h04, 30, s1);
		pwr <= 1'b1;
		cyc(8);
		chk("stored kept", s1, sp);
		pwr <= 1'b0;
		push(8'h10, 4, s2);
		chk("clear", 16'h0100, s2);
		wr(mode_sel_pkg::OFF_CONFIG, 32'h0205);
		push(8'h04, 30, s1);
		pwr <= 1'b1;
		cyc(8);
		chk("not stored", 16'h0100, sp);
		pwr <= 1'b0;
	endtask : t_ramp
	task automatic t_override;
		wr(mode_sel_pkg::OFF_SLOT_BASE + 8'h14, mode_sel_pkg::FN_OVERRIDE);
		crun_cmd <= 1'b1;
		cyc(6);
		chk("run", 1, run);
		close <= 8'h20;
		cyc(6);
		chk("override stop", 0, run);
		chk("keypad setpoint", 16'h0abc, sp);
		crun_cmd <= 1'b0;
		cyc(4);
		krun <= 1'b1;
		cyc(6);
		chk("keypad run", 1, run);
		krun <= 1'b0;
		close <= 8'h00;
	endtask : t_override
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		cyc(10);
		rst_b_in <= 1'b1;
		cyc(25);
		t_reset();
		t_gain();
		t_comp();
		t_ramp();
		t_override();
		stop_test();
	end
endmodule : drive_input_mode_selector_tb
`default_nettype wire
